//--- verilog/halt_wake_sequence.sv
// The register addresses and the Avalon-MM slave port were chosen for this implementation.
`include "halt_wake_consts.svh"
module halt_wake_sequence
    import halt_wake_pkg::*;
#(
    parameter int PINS         = 8,
    parameter int RECOVERY_CYC = `HW_RECOVERY_CYC,
    parameter int MIN_PULSE    = `HW_MIN_PULSE_CYC
) (
    input  wire logic                    sys_clk,
    input  wire logic                    rst,
    input  wire halt_wake_pkg::av_req_t  av_req,
    output halt_wake_pkg::av_rsp_t       av_rsp,
    input  wire halt_wake_pkg::wake_src_t src_in,
    input  wire logic [PINS-1:0]         port_pins,
    input  wire logic                    halt_req,
    input  wire logic                    irq_ack,
    output halt_wake_pkg::wake_out_t     wake_out,
    output logic [PINS-1:0]              port_value
);
    import halt_wake_pkg::*;

    localparam int CW = $clog2(RECOVERY_CYC + MIN_PULSE + 2);

    if (PINS < 1 || PINS > 32) begin : g_pins_chk
        $error("PINS must be 1..32");
    end
    if (RECOVERY_CYC < 1) begin : g_rec_chk
        $error("RECOVERY_CYC must be at least 1");
    end
    if (MIN_PULSE < 1 || MIN_PULSE > RECOVERY_CYC) begin : g_pulse_chk
        $error("MIN_PULSE must be 1..RECOVERY_CYC");
    end

    typedef struct packed {
        wake_state_t      state;
        logic [CW-1:0]    cnt;
        logic [CW-1:0]    pulse_cnt;
        logic             pulse_seen;
        logic             wd_wake;
        logic             wd_irq_pend;
        logic             irq_en;
        logic             sw_halt;
        logic             wd_irq_mode_cfg;
        logic [PINS-1:0]  wake_en;
        logic [PINS-1:0]  pin_ref;
        logic [PINS-1:0]  port_in;
        logic [3:0]       cause;
        logic [3:0]       rst_cnt;
        logic             ack;
        logic [31:0]      rdata;
        logic             recovery_done;
        logic             sys_reset_req;
        logic             wdog_irq_req;
        logic             halted;
    } state_t;

    state_t s_q;
    state_t s_d;

    logic [PINS-1:0] pins_s;
    logic [3:0]      ctl_s;
    logic            wd_to;
    logic            wd_irq;
    logic            ext_rst_n;
    logic            dbg_n;

    pin_sync #(.WIDTH(PINS + 4)) u_sync (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .async_in ({port_pins, src_in.wdog_timeout, src_in.wdog_irq_mode,
                    src_in.ext_reset_n, src_in.debug_n}),
        .sync_out ({pins_s, ctl_s})
    );

    assign wd_to     = ctl_s[3];
    assign wd_irq    = ctl_s[2];
    assign ext_rst_n = ctl_s[1];
    assign dbg_n     = ctl_s[0];

    function automatic logic [31:0] zext(input logic [PINS-1:0] v);
        logic [31:0] r;
        r = '0;
        r[PINS-1:0] = v;
        return r;
    endfunction : zext

    function automatic logic [3:0] set_bit(input logic [3:0] v,
                                           input int         pos);
        logic [3:0] r;
        r = v;
        r[pos] = 1'b1;
        return r;
    endfunction : set_bit

    logic [PINS-1:0] pin_change;
    logic            bus_req;
    logic            halt_now;

    always_comb begin
        s_d        = s_q;
        pin_change = (pins_s ^ s_q.pin_ref) & s_q.wake_en;
        bus_req    = (av_req.read || av_req.write) && !s_q.ack;
        halt_now   = 1'b0;

        s_d.recovery_done = 1'b0;
        s_d.ack           = 1'b0;

        // register access; one wait state then ack
        if (bus_req) begin
            s_d.ack   = 1'b1;
            s_d.rdata = '0;
            if (av_req.write) begin
                case (av_req.address)
                    `HW_ADDR_CTRL: begin
                        halt_now          = av_req.writedata[`HW_CTRL_HALT_BIT];
                        s_d.wd_irq_mode_cfg =
                            av_req.writedata[`HW_CTRL_WDIRQ_BIT];
                        s_d.irq_en = av_req.writedata[`HW_CTRL_IEN_BIT];
                    end
                    `HW_ADDR_WAKE_EN: s_d.wake_en =
                        av_req.writedata[PINS-1:0];
                    `HW_ADDR_CAUSE: s_d.cause =
                        s_q.cause & ~av_req.writedata[3:0];
                    default: ;
                endcase
            end else begin
                case (av_req.address)
                    `HW_ADDR_CTRL: s_d.rdata = {29'h0, s_q.irq_en,
                        s_q.wd_irq_mode_cfg, s_q.halted};
                    `HW_ADDR_WAKE_EN: s_d.rdata = zext(s_q.wake_en);
                    `HW_ADDR_CAUSE: s_d.rdata = {28'h0, s_q.cause};
                    `HW_ADDR_PORT_IN: s_d.rdata = zext(s_q.port_in);
                    default: s_d.rdata = '0;
                endcase
            end
        end
        s_d.sw_halt = halt_now;

        if (s_q.rst_cnt != '0) begin
            s_d.rst_cnt = s_q.rst_cnt - 4'h1;
        end
        s_d.sys_reset_req = (s_q.rst_cnt != '0);

        // watchdog request waits for irq ack
        if (irq_ack) begin
            s_d.wdog_irq_req = 1'b0;
        end

        case (s_q.state)
            ST_RUN: begin
                s_d.port_in = pins_s;
                if (halt_now || halt_req) begin
                    s_d.state      = ST_HALT;
                    s_d.halted     = 1'b1;
                    s_d.pin_ref    = pins_s;
                    s_d.pulse_seen = 1'b0;
                    s_d.pulse_cnt  = '0;
                end
            end
            ST_HALT: begin
                // port_in held while halted
                if (!ext_rst_n) begin
                    s_d.cause   = set_bit(s_d.cause, `HW_CAUSE_EXT_BIT);
                    s_d.rst_cnt = 4'(`HW_RESET_PULSE_CYC);
                    s_d.state   = ST_RUN;
                    s_d.halted  = 1'b0;
                end else if (!dbg_n) begin
                    s_d.cause   = set_bit(s_d.cause, `HW_CAUSE_DBG_BIT);
                    s_d.rst_cnt = 4'(`HW_RESET_PULSE_CYC);
                    s_d.state   = ST_RUN;
                    s_d.halted  = 1'b0;
                end else if (wd_to) begin
                    s_d.wd_wake     = 1'b1;
                    s_d.wd_irq_pend = wd_irq;
                    s_d.state       = ST_RECOVER;
                    s_d.cnt         = '0;
                end else if (pin_change != '0) begin
                    s_d.pulse_seen = 1'b1;
                    s_d.pulse_cnt  = s_q.pulse_cnt + 1'b1;
                    if (s_q.pulse_cnt + 1'b1 >= CW'(MIN_PULSE)) begin
                        s_d.wd_wake     = 1'b0;
                        s_d.wd_irq_pend = 1'b0;
                        s_d.state       = ST_RECOVER;
                        s_d.cnt         = '0;
                    end
                end else if (s_q.pulse_seen) begin
                    // too short a pulse: no wake, flag only
                    s_d.cause      = set_bit(s_d.cause, `HW_CAUSE_HALT_BIT);
                    s_d.pulse_seen = 1'b0;
                    s_d.pulse_cnt  = '0;
                end
            end
            ST_RECOVER: begin
                s_d.cnt = s_q.cnt + 1'b1;
                if (s_q.cnt + 1'b1 >= CW'(RECOVERY_CYC)) begin
                    s_d.state         = ST_RUN;
                    s_d.halted        = 1'b0;
                    s_d.recovery_done = 1'b1;
                    // pins sampled only now: a level that did not last
                    // through recovery never reaches the input register
                    s_d.port_in       = pins_s;
                    s_d.cause = set_bit(s_d.cause,
                                        `HW_CAUSE_HALT_BIT);
                    if (s_q.wd_wake) begin
                        s_d.cause = set_bit(s_d.cause,
                                            `HW_CAUSE_WDOG_BIT);
                    end
                    if (s_q.wd_wake && s_q.wd_irq_pend && s_q.irq_en) begin
                        s_d.wdog_irq_req = 1'b1;
                    end
                end
            end
            default: begin
                s_d.state  = ST_RUN;
                s_d.halted = 1'b0;
            end
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_q       <= '0;
            s_q.state <= ST_RUN;
        end else begin
            s_q <= s_d;
        end
    end

    assign av_rsp.readdata    = s_q.rdata;
    assign av_rsp.waitrequest = !s_q.ack;
    assign wake_out.recovery_done = s_q.recovery_done;
    assign wake_out.sys_reset_req = s_q.sys_reset_req;
    assign wake_out.wdog_irq_req  = s_q.wdog_irq_req;
    assign wake_out.halted        = s_q.halted;
    assign port_value             = s_q.port_in;
endmodule : halt_wake_sequence

//--- verilog/halt_wake_consts.svh
`ifndef HALT_WAKE_CONSTS_SVH
`define HALT_WAKE_CONSTS_SVH

// register map (word aligned byte addresses)
`define HW_ADDR_CTRL        4'h0
`define HW_ADDR_WAKE_EN     4'h4
`define HW_ADDR_CAUSE       4'h8
`define HW_ADDR_PORT_IN     4'hc

// control register fields
`define HW_CTRL_HALT_BIT    0
`define HW_CTRL_WDIRQ_BIT   1
`define HW_CTRL_IEN_BIT     2

// reset cause register fields
`define HW_CAUSE_HALT_BIT   0
`define HW_CAUSE_WDOG_BIT   1
`define HW_CAUSE_EXT_BIT    2
`define HW_CAUSE_DBG_BIT    3

// timing
`define HW_CLK_MHZ          40
`define HW_RECOVERY_NS      1000
`define HW_RECOVERY_CYC     ((`HW_RECOVERY_NS * `HW_CLK_MHZ + 999) / 1000)
`define HW_MIN_PULSE_NS     100
`define HW_MIN_PULSE_CYC    ((`HW_MIN_PULSE_NS * `HW_CLK_MHZ + 999) / 1000)
`define HW_RESET_PULSE_CYC  4

`endif

//--- verilog/halt_wake_pkg.sv
package halt_wake_pkg;
    typedef enum logic [2:0] {
        ST_RUN     = 3'b001,
        ST_HALT    = 3'b010,
        ST_RECOVER = 3'b100
    } wake_state_t;

    typedef struct packed {
        logic [3:0]  address;
        logic        read;
        logic        write;
        logic [31:0] writedata;
    } av_req_t;

    typedef struct packed {
        logic [31:0] readdata;
        logic        waitrequest;
    } av_rsp_t;

    typedef struct packed {
        logic wdog_timeout;
        logic wdog_irq_mode;
        logic ext_reset_n;
        logic debug_n;
    } wake_src_t;

    typedef struct packed {
        logic recovery_done;
        logic sys_reset_req;
        logic wdog_irq_req;
        logic halted;
    } wake_out_t;
endpackage : halt_wake_pkg

//--- verilog/pin_sync.sv
module pin_sync #(
    parameter int WIDTH = 8
) (
    input  wire logic             sys_clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;

    if (WIDTH < 1) begin : g_width_chk
        $error("pin_sync: WIDTH must be positive");
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            meta_q   <= '0;
            sync_out <= '0;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule : pin_sync

//--- tb/halt_wake_monitor.sv
module halt_wake_monitor
    import halt_wake_pkg::*;
#(
    parameter int PINS         = 8,
    parameter int RECOVERY_CYC = 40,
    parameter int MIN_PULSE    = 4
) (
    input wire logic                     sys_clk,
    input wire logic                     rst,
    input wire halt_wake_pkg::av_req_t   av_req,
    input wire halt_wake_pkg::av_rsp_t   av_rsp,
    input wire halt_wake_pkg::wake_src_t src_in,
    input wire logic [PINS-1:0]          port_pins,
    input wire logic                     halt_req,
    input wire logic                     irq_ack,
    input wire halt_wake_pkg::wake_out_t wake_out,
    input wire logic [PINS-1:0]          port_value
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int REC_LO = RECOVERY_CYC - 4;
    localparam int REC_HI = RECOVERY_CYC + 12;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    done_pulse_a: assert property (wake_out.recovery_done
        |=> !wake_out.recovery_done) else $error("done pulse too long");
    done_leaves_a: assert property (wake_out.recovery_done
        |-> ##[0:1] !wake_out.halted) else $error("halt kept after done");
    reset_width_a: assert property ($rose(wake_out.sys_reset_req)
        |-> wake_out.sys_reset_req[*4]) else $error("reset pulse short");
    irq_after_a: assert property ($rose(wake_out.wdog_irq_req)
        |-> wake_out.recovery_done || $past(wake_out.recovery_done))
        else $error("irq before recovery end");
    irq_hold_a: assert property (wake_out.wdog_irq_req && !irq_ack
        |=> wake_out.wdog_irq_req) else $error("irq dropped without ack");
    ack_once_a: assert property (!av_rsp.waitrequest
        |=> av_rsp.waitrequest) else $error("ack longer than one cycle");
    ack_cause_a: assert property ($fell(av_rsp.waitrequest)
        |-> $past(av_req.read || av_req.write)) else $error("stray ack");
    port_frozen_a: assert property (wake_out.halted &&
        $past(wake_out.halted) && !wake_out.recovery_done
        |-> $stable(port_value)) else $error("port value moved in halt");
    ext_reset_a: assert property (wake_out.halted &&
        $fell(src_in.ext_reset_n) |-> ##[1:8] wake_out.sys_reset_req)
        else $error("no reset from reset pin");
    debug_reset_a: assert property (wake_out.halted &&
        $fell(src_in.debug_n) |-> ##[1:8] wake_out.sys_reset_req)
        else $error("no reset from debug pin");
    wdog_wake_a: assert property (wake_out.halted &&
        $rose(src_in.wdog_timeout) |-> ##[REC_LO:REC_HI]
        wake_out.recovery_done) else $error("watchdog wake late");

    cover property (wake_out.recovery_done);
    cover property ($rose(wake_out.sys_reset_req));
    cover property ($rose(wake_out.wdog_irq_req));
endmodule : halt_wake_monitor

//--- tb/cpu_irq_model.sv
module cpu_irq_model
    import halt_wake_pkg::*;
(
    input  wire logic                     sys_clk,
    input  wire logic                     rst,
    input  wire halt_wake_pkg::wake_out_t wake_out,
    input  wire logic [3:0]               ack_delay,
    output logic                          irq_ack
);
    timeunit 1ns;
    timeprecision 1ps;
    int wait_cnt;
    // services the request only once the core runs again
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wait_cnt <= 0;
            irq_ack  <= 1'b0;
        end else if (irq_ack) begin
            irq_ack <= 1'b0;
        end else if (wake_out.wdog_irq_req
                     && !wake_out.halted) begin
            wait_cnt <= wait_cnt + 1;
            if (wait_cnt >= int'(ack_delay)) begin
                irq_ack  <= 1'b1;
                wait_cnt <= 0;
            end
        end
    end
endmodule : cpu_irq_model

//--- tb/stop_mode_recovery_tb.sv
`include "halt_wake_consts.svh"
module stop_mode_recovery_tb import halt_wake_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk, rst, halt_req, irq_ack;
    av_req_t     av_req;
    av_rsp_t     av_rsp;
    wake_src_t   src_in;
    wake_out_t   wake_out;
    logic [7:0]  port_pins, port_value, pv;
    logic [31:0] rd;
    logic [3:0]  ack_delay;
    int          err_count, checks_done, seed, idx, k;
    int          rst_seen, base, exp_cause;

    halt_wake_sequence #(.PINS(8), .RECOVERY_CYC(40), .MIN_PULSE(4))
        halt_wake_sequence_inst (.sys_clk(sys_clk), .rst(rst),
        .av_req(av_req), .av_rsp(av_rsp), .src_in(src_in),
        .port_pins(port_pins), .halt_req(halt_req), .irq_ack(irq_ack),
        .wake_out(wake_out), .port_value(port_value));
    cpu_irq_model cpu_irq_model_inst (.sys_clk(sys_clk), .rst(rst),
        .wake_out(wake_out), .ack_delay(ack_delay), .irq_ack(irq_ack));

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        if (wake_out.sys_reset_req === 1'b1) rst_seen <= rst_seen + 1;
    end

    task automatic results();
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : results
    task automatic chk(string w, logic [31:0] e, logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            err_count++;
            $display("Error %s expected %h seen %h", w, e, g);
        end
    endtask : chk
    task automatic bus(logic wr, logic [3:0] a, logic [31:0] wd);
        int n;
        n = 0;
        av_req <= '{a, !wr, wr, wd};
        do begin
            @(posedge sys_clk);
            n++;
        end while (av_rsp.waitrequest !== 1'b0 && n < 50);
        rd = av_rsp.readdata;
        av_req <= '0;
        @(posedge sys_clk);
        if (n >= 50) chk("bus timeout", 0, 1);
        if (n >= 50) results();
    endtask : bus
    task automatic wait_ev(bit sel);
        int n;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while ((sel ? wake_out.sys_reset_req : wake_out.recovery_done)
                   !== 1'b1 && n < 200);
        if (n >= 200) chk("event timeout", 0, 1);
        if (n >= 200) results();
    endtask : wait_ev

    initial begin
        seed = 32'h0cc86620;
        rst = 1'b1;
        av_req = '0;
        halt_req = 1'b0;
        exp_cause = 0;
        src_in = 4'h3;
        port_pins = 8'($random(seed));
        ack_delay = 4'($random(seed));
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        bus(0, `HW_ADDR_CAUSE, 0);
        chk("cause reset", exp_cause, rd);
        bus(1, 4'h2, '1);
        bus(0, 4'h2, 0);
        chk("unmapped", 0, rd);
        for (k = 0; k < 2; k++) begin
            idx = {$random(seed)} % 8;
            port_pins <= 8'($random(seed)) & ~(8'h1 << idx) | (8'(k) << idx);
            bus(1, `HW_ADDR_WAKE_EN, 32'h1 << idx);
            bus(0, `HW_ADDR_WAKE_EN, 0);
            chk("wake enable", 32'h1 << idx, rd);
            bus(0, `HW_ADDR_PORT_IN, 0);
            chk("port in", port_pins, rd);
            bus(1, `HW_ADDR_CTRL, 1);
            repeat (3) @(posedge sys_clk);
            pv = port_pins;
            port_pins[idx ^ 1] <= ~port_pins[idx ^ 1];
            @(posedge sys_clk);
            port_pins[idx] <= ~port_pins[idx];
            @(posedge sys_clk);
            port_pins[idx] <= ~port_pins[idx];
            repeat (60) @(posedge sys_clk);
            exp_cause = exp_cause | 1;
            chk("still halted", 1, wake_out.halted);
            chk("frozen port", pv, port_value);
            bus(0, `HW_ADDR_CAUSE, 0);
            chk("short pulse", exp_cause, rd);
            bus(1, `HW_ADDR_CAUSE, 32'hf);
            exp_cause = 0;
            port_pins[idx] <= ~port_pins[idx];
            wait_ev(0);
            exp_cause = exp_cause | 1;
            repeat (4) @(posedge sys_clk);
            chk("woken", 0, wake_out.halted);
            chk("port after", port_pins, port_value);
            bus(0, `HW_ADDR_CAUSE, 0);
            chk("pin cause", exp_cause, rd);
            bus(1, `HW_ADDR_CAUSE, 32'hf);
            exp_cause = 0;
        end
        for (k = 0; k < 3; k++) begin
            base = rst_seen;
            src_in.wdog_irq_mode <= (k != 0);
            bus(1, `HW_ADDR_CTRL, {29'h0, k != 2, k != 0, 1'b1});
            repeat (3) @(posedge sys_clk);
            src_in.wdog_timeout <= 1'b1;
            repeat (3) @(posedge sys_clk);
            src_in.wdog_timeout <= 1'b0;
            wait_ev(0);
            exp_cause = exp_cause | 3;
            @(posedge sys_clk);
            chk("wdog irq", k == 1, wake_out.wdog_irq_req);
            chk("no sys reset", base, rst_seen);
            bus(0, `HW_ADDR_CAUSE, 0);
            chk("wdog cause", exp_cause, rd);
            bus(1, `HW_ADDR_CAUSE, 32'hf);
            exp_cause = 0;
            bus(0, `HW_ADDR_CTRL, 0);
            chk("ctrl", {k != 2, k != 0, 1'b0}, rd);
            repeat (30) @(posedge sys_clk);
            chk("irq served", 0, wake_out.wdog_irq_req);
        end
        for (k = 0; k < 2; k++) begin
            halt_req <= 1'b1;
            @(posedge sys_clk);
            halt_req <= 1'b0;
            repeat (3) @(posedge sys_clk);
            if (k == 0) src_in.ext_reset_n <= 1'b0;
            else src_in.debug_n <= 1'b0;
            wait_ev(1);
            exp_cause = exp_cause | (4 << k);
            src_in.ext_reset_n <= 1'b1;
            src_in.debug_n <= 1'b1;
            repeat (8) @(posedge sys_clk);
            chk("reset halted", 0, wake_out.halted);
            bus(0, `HW_ADDR_CAUSE, 0);
            chk("reset cause", exp_cause, rd);
            bus(1, `HW_ADDR_CAUSE, 32'hf);
            exp_cause = 0;
        end
        results();
    end
endmodule : stop_mode_recovery_tb

bind halt_wake_sequence halt_wake_monitor #(.PINS(PINS),
    .RECOVERY_CYC(RECOVERY_CYC), .MIN_PULSE(MIN_PULSE))
    halt_wake_monitor_inst (.sys_clk(sys_clk), .rst(rst),
    .av_req(av_req), .av_rsp(av_rsp), .src_in(src_in),
    .port_pins(port_pins), .halt_req(halt_req), .irq_ack(irq_ack),
    .wake_out(wake_out), .port_value(port_value));
